// File: rtl/can_filter_pkg.sv
// register map, field layout and reset values of the acceptance filter block
`default_nettype none
package can_filter_pkg;
	localparam int          NUM_FILTERS     = 16;
	localparam int          NUM_MASKS       = 3;
	localparam int          ADDR_W          = 12;
	// word offsets (byte addresses)
	localparam logic [11:0] OFF_BUF_PTR_0   = 12'h000;
	localparam logic [11:0] OFF_FILTER_EN   = 12'h010;
	localparam logic [11:0] OFF_MASK_SEL_LO = 12'h014;
	localparam logic [11:0] OFF_MASK_SEL_HI = 12'h018;
	localparam logic [11:0] OFF_STATUS      = 12'h01C;
	localparam logic [11:0] OFF_MASK_STD_0  = 12'h040;
	localparam logic [11:0] OFF_MASK_EXT_0  = 12'h060;
	localparam logic [11:0] OFF_FILT_STD_0  = 12'h100;
	localparam logic [11:0] OFF_FILT_EXT_0  = 12'h200;
	localparam logic [15:0] RST_BUF_PTR     = 16'h0000;
	localparam logic [15:0] RST_FILTER_EN   = 16'hFFFF;
	localparam logic [15:0] RST_MASK_SEL    = 16'h0000;
	localparam logic [15:0] RST_ID          = 16'h0000;
	// bits 4 and 2 of the standard id registers are not implemented
	localparam logic [15:0] STD_ID_IMPL     = 16'hFFEB;
	localparam int          STD_LSB         = 5;
	localparam int          TYPE_BIT        = 3;
	localparam logic [3:0]  DEST_FIFO       = 4'hF;
	localparam logic [1:0]  MSEL_RESERVED   = 2'h3;
endpackage : can_filter_pkg
`default_nettype wire

// File: rtl/can_acceptance_filter_routing.sv
// acceptance filtering and receive buffer routing with an apb register slave
// Overview of operation
// RQ1 - a hit stores the message in buffer 0 to 14 for pointer codes 0000 to 1110 and in the fifo for code 1111.
// RQ2 - destination pointers are packed four per 16-bit register, filter 4k+j at bits 4j+3 to 4j.
// RQ3 - standard id bits 15-5 of a filter must equal the message bits wherever the mask includes them.
// RQ4 - extended bits 17-16 (std register bits 1-0) and 15-0 (ext register) must equal included message bits.
// RQ5 - with the mask type bit set, the filter bit 3 selector picks extended (1) or standard (0) messages only.
// RQ6 - a two-bit mask source per filter picks mask 0, 1 or 2; code 11 is reserved.
// RQ7 - the low mask select register holds filters 0 to 7, filter n at bits 2n+1 to 2n.
// RQ8 - bits 4 and 2 of each standard id register read as zero and ignore writes.
// RQ9 - a mask bit of 1 includes the id bit in the comparison, 0 makes it a don't-care.
// RQ10 - with the mask type bit clear, standard or extended messages are accepted if included bits match.
// RQ11 - only filters whose enable bit is 1 can hit.
// RQ12 - among several hits the lowest-numbered filter decides the destination.
`default_nettype none
module can_acceptance_filter_routing #(
	parameter int NUM_FILTERS = can_filter_pkg::NUM_FILTERS
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_msg_valid,
	input  wire logic        i_msg_ext,
	input  wire logic [10:0] i_msg_std_id,
	input  wire logic [17:0] i_msg_ext_id,
	output logic             o_route_valid,
	output logic             o_route_fifo,
	output logic      [3:0]  o_route_dest,
	output logic      [3:0]  o_route_filter,
	output logic             o_route_reject
);
	localparam int NF = NUM_FILTERS;
	localparam int NM = can_filter_pkg::NUM_MASKS;

	logic [15:0] buf_ptr_reg  [4];
	logic [15:0] filt_std_reg [NF];
	logic [15:0] filt_ext_reg [NF];
	logic [15:0] mask_std_reg [NM];
	logic [15:0] mask_ext_reg [NM];
	logic [15:0] filter_en_reg;
	logic [15:0] mask_sel_lo_reg;
	logic [15:0] mask_sel_hi_reg;
	logic [15:0] hit_count_reg;
	logic [31:0] prdata_next;
	logic        addr_ok_next;
	logic        wr_en;
	logic        access;

	assign access = i_psel && i_penable;
	assign wr_en  = access && i_pwrite && addr_ok_next;

	// index decode used by several address windows
	function automatic logic in_window(input logic [11:0] a, input logic [11:0] base, input int n);
		logic ok;
		ok = (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'b00);
		return ok;
	endfunction : in_window

	// read mux and address check
	always_comb begin
		logic [11:0] rel;
		rel          = 12'h000;
		prdata_next  = 32'h0000_0000;
		addr_ok_next = 1'b1;
		if (in_window(i_paddr, can_filter_pkg::OFF_BUF_PTR_0, 4)) begin
			rel         = i_paddr - can_filter_pkg::OFF_BUF_PTR_0;
			prdata_next = {16'h0000, buf_ptr_reg[rel[3:2]]};
		end else if (i_paddr == can_filter_pkg::OFF_FILTER_EN) begin
			prdata_next = {16'h0000, filter_en_reg};
		end else if (i_paddr == can_filter_pkg::OFF_MASK_SEL_LO) begin
			prdata_next = {16'h0000, mask_sel_lo_reg};
		end else if (i_paddr == can_filter_pkg::OFF_MASK_SEL_HI) begin
			prdata_next = {16'h0000, mask_sel_hi_reg};
		end else if (i_paddr == can_filter_pkg::OFF_STATUS) begin
			prdata_next = {16'h0000, hit_count_reg};
		end else if (in_window(i_paddr, can_filter_pkg::OFF_MASK_STD_0, NM)) begin
			rel         = i_paddr - can_filter_pkg::OFF_MASK_STD_0;
			prdata_next = {16'h0000, mask_std_reg[rel[3:2]] & can_filter_pkg::STD_ID_IMPL};
		end else if (in_window(i_paddr, can_filter_pkg::OFF_MASK_EXT_0, NM)) begin
			rel         = i_paddr - can_filter_pkg::OFF_MASK_EXT_0;
			prdata_next = {16'h0000, mask_ext_reg[rel[3:2]]};
		end else if (in_window(i_paddr, can_filter_pkg::OFF_FILT_STD_0, NF)) begin
			rel         = i_paddr - can_filter_pkg::OFF_FILT_STD_0;
			prdata_next = {16'h0000, filt_std_reg[rel[5:2]]}; // see RQ8
		end else if (in_window(i_paddr, can_filter_pkg::OFF_FILT_EXT_0, NF)) begin
			rel         = i_paddr - can_filter_pkg::OFF_FILT_EXT_0;
			prdata_next = {16'h0000, filt_ext_reg[rel[5:2]]};
		end else begin
			addr_ok_next = 1'b0;
		end
	end

	// one wait state: answer in the cycle after the access phase starts
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= access && !o_pready;
			o_pslverr <= access && !o_pready && !addr_ok_next;
			o_prdata  <= (access && !o_pready && !i_pwrite) ? prdata_next : 32'h0000_0000;
		end
	end

	// register writes happen on the completing edge only
	// every window base is aligned to its own size, so the low address bits index the arrays directly
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < 4; k++) begin
				buf_ptr_reg[k] <= can_filter_pkg::RST_BUF_PTR;
			end
			for (int k = 0; k < NM; k++) begin
				mask_std_reg[k] <= can_filter_pkg::RST_ID;
				mask_ext_reg[k] <= can_filter_pkg::RST_ID;
			end
			for (int k = 0; k < NF; k++) begin
				filt_std_reg[k] <= can_filter_pkg::RST_ID;
				filt_ext_reg[k] <= can_filter_pkg::RST_ID;
			end
			filter_en_reg   <= can_filter_pkg::RST_FILTER_EN;
			mask_sel_lo_reg <= can_filter_pkg::RST_MASK_SEL;
			mask_sel_hi_reg <= can_filter_pkg::RST_MASK_SEL;
		end else if (wr_en && o_pready) begin
			if (in_window(i_paddr, can_filter_pkg::OFF_BUF_PTR_0, 4)) begin
				buf_ptr_reg[i_paddr[3:2]] <= i_pwdata[15:0]; // see RQ2
			end else if (i_paddr == can_filter_pkg::OFF_FILTER_EN) begin
				filter_en_reg <= i_pwdata[15:0];
			end else if (i_paddr == can_filter_pkg::OFF_MASK_SEL_LO) begin
				mask_sel_lo_reg <= i_pwdata[15:0]; // see RQ7
			end else if (i_paddr == can_filter_pkg::OFF_MASK_SEL_HI) begin
				mask_sel_hi_reg <= i_pwdata[15:0];
			end else if (in_window(i_paddr, can_filter_pkg::OFF_MASK_STD_0, NM)) begin
				mask_std_reg[i_paddr[3:2]] <= i_pwdata[15:0] & can_filter_pkg::STD_ID_IMPL;
			end else if (in_window(i_paddr, can_filter_pkg::OFF_MASK_EXT_0, NM)) begin
				mask_ext_reg[i_paddr[3:2]] <= i_pwdata[15:0];
			end else if (in_window(i_paddr, can_filter_pkg::OFF_FILT_STD_0, NF)) begin
				filt_std_reg[i_paddr[5:2]] <= i_pwdata[15:0] & can_filter_pkg::STD_ID_IMPL; // see RQ8
			end else if (in_window(i_paddr, can_filter_pkg::OFF_FILT_EXT_0, NF)) begin
				filt_ext_reg[i_paddr[5:2]] <= i_pwdata[15:0];
			end
		end
	end

	// per-filter comparison
	logic [NF-1:0] hit;
	logic [31:0]   mask_sel_all;
	logic [15:0]   msg_std_word;
	assign mask_sel_all = {mask_sel_hi_reg, mask_sel_lo_reg};
	assign msg_std_word = {i_msg_std_id, 3'b000, i_msg_ext_id[17:16]};

	generate
		for (genvar f = 0; f < NF; f++) begin : g_filter
			logic [1:0]  msel;
			logic [15:0] m_std;
			logic [15:0] m_ext;
			logic        id_ok;
			logic        type_ok;
			logic [15:0] cmp_std;
			assign msel = mask_sel_all[2*f +: 2]; // see RQ7
			// reserved code 11 falls back to mask 0, a plain choice
			assign m_std = (msel == 2'b01) ? mask_std_reg[1] :
				(msel == 2'b10) ? mask_std_reg[2] : mask_std_reg[0]; // see RQ6
			assign m_ext = (msel == 2'b01) ? mask_ext_reg[1] :
				(msel == 2'b10) ? mask_ext_reg[2] : mask_ext_reg[0]; // see RQ6
			// only id bits take part; bits 4..2 are excluded from the std compare
			assign cmp_std = can_filter_pkg::STD_ID_IMPL & ~16'h0008;
			// extended bits only count for extended messages
			assign id_ok = ((((msg_std_word ^ filt_std_reg[f]) & m_std) & cmp_std &
				(i_msg_ext ? 16'hFFFF : 16'hFFE0)) == 16'h0000) && // see RQ3 RQ9
				(!i_msg_ext || (((i_msg_ext_id[15:0] ^ filt_ext_reg[f]) & m_ext) == 16'h0000)); // see RQ4
			assign type_ok = !m_std[can_filter_pkg::TYPE_BIT] ||
				(filt_std_reg[f][can_filter_pkg::TYPE_BIT] == i_msg_ext); // see RQ5 RQ10
			assign hit[f] = filter_en_reg[f] && id_ok && type_ok; // see RQ11
		end
	endgenerate

	// lowest-numbered hit wins
	logic       any_hit;
	logic [3:0] win_idx;
	always_comb begin
		any_hit = 1'b0;
		win_idx = 4'h0;
		for (int k = NF - 1; k >= 0; k--) begin
			if (hit[k]) begin
				any_hit = 1'b1; // see RQ12
				win_idx = 4'(k);
			end
		end
	end

	logic [3:0] win_dest;
	assign win_dest = buf_ptr_reg[win_idx[3:2]][4*win_idx[1:0] +: 4]; // see RQ2

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_route_valid  <= 1'b0;
			o_route_fifo   <= 1'b0;
			o_route_dest   <= 4'h0;
			o_route_filter <= 4'h0;
			o_route_reject <= 1'b0;
		end else begin
			o_route_valid  <= i_msg_valid && any_hit;
			o_route_reject <= i_msg_valid && !any_hit;
			o_route_fifo   <= i_msg_valid && any_hit && (win_dest == can_filter_pkg::DEST_FIFO); // see RQ1
			o_route_dest   <= (i_msg_valid && any_hit) ? win_dest : 4'h0; // see RQ1
			o_route_filter <= (i_msg_valid && any_hit) ? win_idx : 4'h0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hit_count_reg <= 16'h0000;
		end else if (i_msg_valid && any_hit) begin
			hit_count_reg <= hit_count_reg + 16'h0001;
		end
	end

	a_disabled_no_hit: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && filter_en_reg == 16'h0000) |=> !o_route_valid && o_route_reject) // see RQ11
		else $error("hit with all filters disabled");
	a_fifo_code_route: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_route_valid |-> (o_route_fifo == (o_route_dest == can_filter_pkg::DEST_FIFO))) // see RQ1
		else $error("fifo flag disagrees with pointer");
	a_lowest_filter_wins: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && hit[0]) |=> o_route_valid && o_route_filter == 4'h0) // see RQ12
		else $error("filter 0 hit not chosen");
	a_dest_from_pointer: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && hit[0]) |=> o_route_dest == $past(buf_ptr_reg[0][3:0])) // see RQ2
		else $error("destination not from pointer");
	a_std_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(filt_std_reg[0][4] == 1'b0) && (filt_std_reg[0][2] == 1'b0)) // see RQ8
		else $error("unimplemented std bits set");
	a_type_gate: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && mask_std_reg[0][3] && mask_sel_lo_reg[1:0] == 2'b00 &&
		filt_std_reg[0][3] != i_msg_ext) |-> !hit[0]) // see RQ5
		else $error("type selector ignored");
	a_std_id_mismatch: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(mask_sel_lo_reg[1:0] == 2'b00 && mask_std_reg[0][15] &&
		filt_std_reg[0][15] != i_msg_std_id[10]) |-> !hit[0]) // see RQ3
		else $error("included std bit mismatch hit");
	a_ext_id_mismatch: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_ext && mask_sel_lo_reg[1:0] == 2'b01 && mask_ext_reg[1][0] &&
		filt_ext_reg[0][0] != i_msg_ext_id[0]) |-> !hit[0]) // see RQ4
		else $error("included ext bit mismatch hit");
	a_dont_care_all: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && filter_en_reg[0] && mask_sel_lo_reg[1:0] == 2'b10 &&
		mask_std_reg[2] == 16'h0000 && mask_ext_reg[2] == 16'h0000) |=> o_route_valid) // see RQ9 RQ10 RQ6
		else $error("zero mask did not accept");
	c_route_buffer: cover property (@(posedge i_sys_clk) o_route_valid && !o_route_fifo);
	c_route_fifo:   cover property (@(posedge i_sys_clk) o_route_fifo);
	c_reject:       cover property (@(posedge i_sys_clk) o_route_reject);
	c_multi_hit:    cover property (@(posedge i_sys_clk) i_msg_valid && hit[0] && hit[1]);
	c_ext_accept:   cover property (@(posedge i_sys_clk) i_msg_valid && i_msg_ext && any_hit);
	// bus answer: one pulse per access, error only with it
	a_pready_single_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_pready |=> !o_pready)
		else $error("ready held for more than one cycle");
	a_error_with_ready: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_pslverr |-> o_pready)
		else $error("error without ready");
	a_read_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_pready |-> (o_prdata[31:16] == 16'h0000))
		else $error("upper read half not zero");
	a_enable_write_only: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(filter_en_reg != $past(filter_en_reg)) |->
		$past(o_pready && i_pwrite && i_paddr == can_filter_pkg::OFF_FILTER_EN)) // see RQ11
		else $error("filter enables changed without a write");
	// routing answers: exactly one of accept or reject, one cycle after the message
	a_accept_reject_excl: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!(o_route_valid && o_route_reject)) // see RQ11
		else $error("accept and reject together");
	a_message_answered: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_msg_valid |=> (o_route_valid || o_route_reject)) // see RQ11
		else $error("message not answered");
	a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!i_msg_valid |=> (!o_route_valid && !o_route_reject))
		else $error("route answer without message");
	a_idle_fields_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!o_route_valid |-> (o_route_dest == 4'h0 && o_route_filter == 4'h0 && !o_route_fifo)) // see RQ1
		else $error("route fields set without accept");
	a_hit_counter_step: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_msg_valid && any_hit) |=> (hit_count_reg == $past(hit_count_reg) + 16'h0001))
		else $error("hit counter did not advance");
	a_mask_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(mask_std_reg[0][4] == 1'b0) && (mask_std_reg[0][2] == 1'b0)) // see RQ8
		else $error("unimplemented mask bits set");
	// per-filter checks: held bits and the enable gate
	generate
		for (genvar f = 0; f < NF; f++) begin : g_filter_chk
			a_filter_bits_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
				(filt_std_reg[f][4] == 1'b0) && (filt_std_reg[f][2] == 1'b0)) // see RQ8
				else $error("unimplemented filter bits set");
			a_hit_needs_enable: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
				hit[f] |-> filter_en_reg[f]) // see RQ11
				else $error("disabled filter hit");
		end
	endgenerate
endmodule : can_acceptance_filter_routing
`default_nettype wire

// File: dv/can_msg_source.sv
// message source standing in for the can bus side of the filter
`default_nettype none
module can_msg_source (
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_send,
	input  wire logic        i_ext,
	input  wire logic [10:0] i_std,
	input  wire logic [17:0] i_eid,
	output logic             o_msg_valid,
	output logic             o_msg_ext,
	output logic      [10:0] o_msg_std_id,
	output logic      [17:0] o_msg_ext_id
);
	timeunit 1ns;
	timeprecision 1ps;
	// between frames the ids toggle so a stale id is never mistaken for a live one
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_msg_valid  <= 1'b0;
			o_msg_ext    <= 1'b0;
			o_msg_std_id <= 11'h000;
			o_msg_ext_id <= 18'h0_0000;
		end else if (i_send) begin
			o_msg_valid  <= 1'b1;
			o_msg_ext    <= i_ext;
			o_msg_std_id <= i_std;
			o_msg_ext_id <= i_eid;
		end else begin
			o_msg_valid  <= 1'b0;
			o_msg_std_id <= ~o_msg_std_id;
			o_msg_ext_id <= ~o_msg_ext_id;
		end
	end
endmodule : can_msg_source
`default_nettype wire

// File: dv/tb.sv
// register and routing testbench for the acceptance filter
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        send, s_ext, mv, me, rv, rf, rj;
	logic [10:0] s_std, ms;
	logic [17:0] s_eid, mx;
	logic [3:0]  rdst, rfl;
	int          err_count, samples_checked;
	logic [15:0] ptrs [4] = '{16'hCDEF, 16'h89AB, 16'h4567, 16'h0123};

	can_msg_source can_msg_source_i (.i_sys_clk(clk), .i_arst_n(arst_n), .i_send(send), .i_ext(s_ext),
		.i_std(s_std), .i_eid(s_eid), .o_msg_valid(mv), .o_msg_ext(me), .o_msg_std_id(ms), .o_msg_ext_id(mx));
	can_acceptance_filter_routing can_acceptance_filter_routing_i (.i_sys_clk(clk), .i_arst_n(arst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_msg_valid(mv), .i_msg_ext(me),
		.i_msg_std_id(ms), .i_msg_ext_id(mx), .o_route_valid(rv), .o_route_fifo(rf), .o_route_dest(rdst),
		.o_route_filter(rfl), .o_route_reject(rj));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	task automatic compare(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask : compare

	// reads of pready right after the edge see the value that edge sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
		compare({31'h0, e}, 32'h0000_0000);
	endtask : wr

	task automatic rdk(input logic [11:0] a, input logic [31:0] want, input logic eerr);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 16'h0000, rd, e);
		compare(rd, want);
		compare({31'h0, e}, {31'h0, eerr});
	endtask : rdk

	task automatic route(input logic x, input logic [10:0] s, input logic [17:0] e, input logic v,
		input logic [3:0] f, input logic [3:0] d);
		int n;
		@(posedge clk);
		send  <= 1'b1;
		s_ext <= x;
		s_std <= s;
		s_eid <= e;
		@(posedge clk);
		send  <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rv !== 1'b1 && rj !== 1'b1 && n < 8);
		if (n >= 8) begin
			err_count++;
			close_out();
		end
		compare({21'h0, rv, rj, rf, rfl, rdst}, {21'h0, v, !v, v && d == 4'hF, v ? f : 4'h0, v ? d : 4'h0});
	endtask : route

	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, send, s_ext} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		s_std = 11'h000;
		s_eid = 18'h0_0000;
		err_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rdk(can_filter_pkg::OFF_BUF_PTR_0, 32'h0000_0000, 1'b0);
		rdk(can_filter_pkg::OFF_FILTER_EN, 32'h0000_FFFF, 1'b0);
		rdk(can_filter_pkg::OFF_MASK_SEL_LO, 32'h0000_0000, 1'b0);
		rdk(12'h300, 32'h0000_0000, 1'b1);
		wr(can_filter_pkg::OFF_FILT_STD_0 + 12'h00C, 16'hFFFF);
		rdk(can_filter_pkg::OFF_FILT_STD_0 + 12'h00C, 32'h0000_FFEB, 1'b0);
		$display("test registers done");
		for (int r = 0; r < 4; r++) begin
			wr(can_filter_pkg::OFF_BUF_PTR_0 + {r[9:0], 2'b00}, ptrs[r]);
			rdk(can_filter_pkg::OFF_BUF_PTR_0 + {r[9:0], 2'b00}, {16'h0000, ptrs[r]}, 1'b0);
		end
		// masks are all clear, so every enabled filter accepts anything
		for (int k = 0; k < 16; k++) begin
			wr(can_filter_pkg::OFF_FILTER_EN, 16'h0001 << k);
			route(1'b0, k[10:0], 18'h0_0000, 1'b1, k[3:0], 4'hF - k[3:0]);
		end
		wr(can_filter_pkg::OFF_FILTER_EN, 16'hFFF0);
		route(1'b1, 11'h7FF, 18'h3_FFFF, 1'b1, 4'h4, 4'hB);
		wr(can_filter_pkg::OFF_FILTER_EN, 16'h0000);
		route(1'b0, 11'h000, 18'h0_0000, 1'b0, 4'h0, 4'h0);
		$display("test pointers done");
		wr(can_filter_pkg::OFF_MASK_STD_0 + 12'h004, 16'hFFE0);
		wr(can_filter_pkg::OFF_FILT_STD_0 + 12'h004, 16'hB4A0);
		wr(can_filter_pkg::OFF_FILT_STD_0 + 12'h01C, 16'hB4A0);
		wr(can_filter_pkg::OFF_MASK_SEL_LO, 16'h4004);
		wr(can_filter_pkg::OFF_FILTER_EN, 16'h0082);
		route(1'b0, 11'h5A5, 18'h0_0000, 1'b1, 4'h1, 4'hE);
		route(1'b0, 11'h5A4, 18'h0_0000, 1'b0, 4'h0, 4'h0);
		wr(can_filter_pkg::OFF_FILTER_EN, 16'h0080);
		route(1'b0, 11'h5A4, 18'h0_0000, 1'b0, 4'h0, 4'h0);
		route(1'b0, 11'h5A5, 18'h0_0000, 1'b1, 4'h7, 4'h8);
		$display("test standard ids done");
		wr(can_filter_pkg::OFF_MASK_STD_0 + 12'h008, 16'h000B);
		wr(can_filter_pkg::OFF_MASK_EXT_0 + 12'h008, 16'hFFFF);
		wr(can_filter_pkg::OFF_FILT_STD_0 + 12'h008, 16'h000A);
		wr(can_filter_pkg::OFF_FILT_EXT_0 + 12'h008, 16'h1234);
		wr(can_filter_pkg::OFF_MASK_SEL_LO, 16'h0020);
		wr(can_filter_pkg::OFF_FILTER_EN, 16'h0004);
		route(1'b1, 11'h000, 18'h2_1234, 1'b1, 4'h2, 4'hD);
		route(1'b1, 11'h000, 18'h2_1235, 1'b0, 4'h0, 4'h0);
		route(1'b1, 11'h000, 18'h0_1234, 1'b0, 4'h0, 4'h0);
		route(1'b0, 11'h000, 18'h2_1234, 1'b0, 4'h0, 4'h0);
		wr(can_filter_pkg::OFF_MASK_STD_0 + 12'h008, 16'h0003);
		route(1'b0, 11'h000, 18'h2_1234, 1'b1, 4'h2, 4'hD);
		$display("test extended ids done");
		rdk(can_filter_pkg::OFF_STATUS, 32'h0000_0015, 1'b0);
		close_out();
	end
endmodule : tb
`default_nettype wire
